// ### design/dpll_defs.svh
// Purpose: constants for the digital pll core (offsets, fields, resets, widths)
// Assumes: included by its bare name from every design file that needs it
// Notes: register map is reached over apb, one aligned 32-bit word each
//
// Operation
// - all select bits low inhibits the counter
// - modulus is two to the select plus two
// - modulus may change live, no reset needed
// - counter advances only on its own clock
// - up wrap past top gives one carry
// - down wrap below zero gives one borrow
// - idle output toggles at half clock rate
// - carry inserts a pulse, borrow deletes one
// - xor detector high when inputs differ
// - edge detector set/cleared by falling edges only
// - direction and enable sampled on counter clock rise
`ifndef DPLL_DEFS_SVH
`define DPLL_DEFS_SVH

// ****************************************************************
// register map
// ****************************************************************
`define DPLL_ADDR_W 12
`define DPLL_CTRL_OFS 12'h000
`define DPLL_STAT_OFS 12'h004

// ****************************************************************
// fields and reset values
// ****************************************************************
`define DPLL_SEL_W 4
`define DPLL_CTRL_RST 4'h0
`define DPLL_KCNT_W 17
`define DPLL_STAT_IDOUT_BIT 17
`define DPLL_STAT_XOR_BIT 18
`define DPLL_STAT_EDGE_BIT 19
`define DPLL_STAT_BUSY_BIT 20
`define DPLL_SEL_OFF 4'h0

`endif

// ### design/dpll_pkg.sv
// Purpose: shared types and the modulus decode function
// Assumes: dpll_defs.svh gives the widths
// Notes: none
`include "dpll_defs.svh"

package dpll_pkg;

    typedef logic [`DPLL_SEL_W-1:0] dpll_sel_t;
    typedef logic [`DPLL_KCNT_W-1:0] dpll_cnt_t;

    typedef enum logic [2:0] {
        ID_NORM = 3'b000,
        ID_INS_A = 3'b001,
        ID_INS_B = 3'b010,
        ID_INS_C = 3'b011,
        ID_DEL = 3'b100
    } dpll_id_state_e;

    // top value of the counter for a select code; code 1 gives 3 bits, 15 gives 17
    function automatic dpll_cnt_t dpll_mod_mask(input dpll_sel_t sel);
        dpll_cnt_t full;
        full = 17'h1ffff;
        return full >> (4'hf - sel);
    endfunction

endpackage

// ### design/dpll_kcounter.sv
// Purpose: programmable-modulus up/down counter with carry and borrow pulses
// Assumes: k_rise is a one-cycle event marking a rise of the counter clock
// Notes: the stored value is masked on every step so a live modulus change is safe
`timescale 1ns/1ps
`include "dpll_defs.svh"

module dpll_kcounter (
    input wire logic core_clk,                // system clock
    input wire logic rst,                     // sync reset, active high
    input wire logic k_rise,                  // counter clock rising edge event
    input wire logic count_down,              // 0 up, 1 down
    input wire logic counter_enable_n,        // high holds the count
    input wire dpll_pkg::dpll_sel_t mod_sel,  // modulus select
    output dpll_pkg::dpll_cnt_t count_ff,     // counter value
    output logic carry_ff,                    // one-cycle carry pulse
    output logic borrow_ff                    // one-cycle borrow pulse
);
    import dpll_pkg::*;

    dpll_cnt_t mask;
    dpll_cnt_t cur;
    dpll_cnt_t nxt_count;
    logic nxt_carry;
    logic nxt_borrow;
    logic step;

    assign mask = dpll_mod_mask(mod_sel);
    assign cur = count_ff & mask;
    assign step = k_rise && !counter_enable_n && (mod_sel != `DPLL_SEL_OFF);

    always_comb
    begin
        nxt_count = count_ff;
        nxt_carry = 1'b0;
        nxt_borrow = 1'b0;
        if (step)
        begin
            if (!count_down)
            begin
                nxt_count = (cur == mask) ? '0 : ((cur + 17'h00001) & mask);
                nxt_carry = (cur == mask);
            end
            else
            begin
                nxt_count = (cur == '0) ? mask : ((cur - 17'h00001) & mask);
                nxt_borrow = (cur == '0);
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            count_ff <= '0;
            carry_ff <= 1'b0;
            borrow_ff <= 1'b0;
        end
        else
        begin
            count_ff <= nxt_count;
            carry_ff <= nxt_carry;
            borrow_ff <= nxt_borrow;
        end
    end

endmodule

// ### design/dpll_idcirc.sv
// Purpose: increment/decrement circuit, divide by two with pulse insert/delete
// Assumes: id_rise and id_fall are one-cycle events of the i/d clock
// Notes: an insert adds two toggles on i/d clock falls, a delete skips two rises
`timescale 1ns/1ps
`include "dpll_defs.svh"

module dpll_idcirc (
    input wire logic core_clk,   // system clock
    input wire logic rst,        // sync reset, active high
    input wire logic id_rise,    // i/d clock rising edge event
    input wire logic id_fall,    // i/d clock falling edge event
    input wire logic carry,      // insert request pulse
    input wire logic borrow,     // delete request pulse
    output logic id_out_ff,      // divided output
    output logic busy            // insert/delete in progress or pending
);
    import dpll_pkg::*;

    dpll_id_state_e state_ff;
    dpll_id_state_e nxt_state;
    logic pend_ins_ff;
    logic pend_del_ff;
    logic take_ins;
    logic take_del;
    logic toggle;

    always_comb
    begin
        nxt_state = state_ff;
        toggle = 1'b0;
        take_ins = 1'b0;
        take_del = 1'b0;
        unique case (state_ff)
            ID_NORM:
                if (id_rise)
                begin
                    if (pend_del_ff)
                    begin
                        take_del = 1'b1;
                        nxt_state = ID_DEL;
                    end
                    else
                    begin
                        toggle = 1'b1;
                        if (pend_ins_ff)
                        begin
                            take_ins = 1'b1;
                            nxt_state = ID_INS_A;
                        end
                    end
                end
            ID_INS_A:
                if (id_fall)
                begin
                    toggle = 1'b1;
                    nxt_state = ID_INS_B;
                end
            ID_INS_B:
                if (id_rise)
                begin
                    toggle = 1'b1;
                    nxt_state = ID_INS_C;
                end
            ID_INS_C:
                if (id_fall)
                begin
                    toggle = 1'b1;
                    nxt_state = ID_NORM;
                end
            ID_DEL:
                if (id_rise)
                begin
                    nxt_state = ID_NORM;
                end
            default:
                nxt_state = ID_NORM;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            state_ff <= ID_NORM;
            id_out_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            id_out_ff <= id_out_ff ^ toggle;
        end
    end

    // a new request in the cycle it is consumed stays pending
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            pend_ins_ff <= 1'b0;
            pend_del_ff <= 1'b0;
        end
        else
        begin
            pend_ins_ff <= carry | (pend_ins_ff & ~take_ins);
            pend_del_ff <= borrow | (pend_del_ff & ~take_del);
        end
    end

    assign busy = (state_ff != ID_NORM) | pend_ins_ff | pend_del_ff;

endmodule

// ### design/dpll_core.sv
// Purpose: first-order digital pll core with two phase detectors and apb control
// Assumes: k_clk, id_clk and phase inputs are synchronous to core_clk
// Notes: loop clocks are sampled as levels, so each must stay below half core_clk
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/1ps
`include "dpll_defs.svh"

module dpll_core (
    input wire logic core_clk,                     // system clock, 10 mhz
    input wire logic rst,                          // sync reset, active high
    input wire logic [`DPLL_ADDR_W-1:0] paddr,     // apb address
    input wire logic psel,                         // apb select
    input wire logic penable,                      // apb enable
    input wire logic pwrite,                       // apb write
    input wire logic [31:0] pwdata,                // apb write data
    output logic [31:0] prdata,                    // apb read data
    output logic pready,                           // apb ready
    output logic pslverr,                          // apb error
    input wire logic k_clk,                        // loop-filter clock level
    input wire logic id_clk,                       // i/d clock level
    input wire logic count_down,                   // 0 up, 1 down
    input wire logic counter_enable_n,             // high holds counter
    input wire logic xor_ref_phase_in,             // xor detector reference
    input wire logic edge_ref_phase_in,            // edge detector reference
    input wire logic fb_phase_in,                  // feedback phase
    output logic xor_detector_out,                 // xor detector output
    output logic edge_detector_out,                // edge detector output
    output logic id_out                            // i/d circuit output
);
    import dpll_pkg::*;

    // ****************************************************************
    // input edge detection
    // ****************************************************************
    logic k_clk_q_ff;
    logic id_clk_q_ff;
    logic fb_q_ff;
    logic eref_q_ff;
    logic k_rise;
    logic id_rise;
    logic id_fall;
    logic fb_fall;
    logic eref_fall;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            k_clk_q_ff <= 1'b0;
            id_clk_q_ff <= 1'b0;
            fb_q_ff <= 1'b0;
            eref_q_ff <= 1'b0;
        end
        else
        begin
            k_clk_q_ff <= k_clk;
            id_clk_q_ff <= id_clk;
            fb_q_ff <= fb_phase_in;
            eref_q_ff <= edge_ref_phase_in;
        end
    end

    assign k_rise = k_clk & ~k_clk_q_ff;
    assign id_rise = id_clk & ~id_clk_q_ff;
    assign id_fall = ~id_clk & id_clk_q_ff;
    assign fb_fall = ~fb_phase_in & fb_q_ff;
    assign eref_fall = ~edge_ref_phase_in & eref_q_ff;

    // ****************************************************************
    // apb register file
    // ****************************************************************
    dpll_sel_t mod_sel_ff;
    dpll_cnt_t count;
    logic carry;
    logic borrow;
    logic id_busy;
    logic [31:0] stat_word;
    logic setup;
    logic hit_ctrl;
    logic hit_stat;

    assign setup = psel & ~penable;
    assign hit_ctrl = (paddr == `DPLL_CTRL_OFS);
    assign hit_stat = (paddr == `DPLL_STAT_OFS);
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~(hit_ctrl | hit_stat);

    always_comb
    begin
        stat_word = '0;
        stat_word[`DPLL_KCNT_W-1:0] = count;
        stat_word[`DPLL_STAT_IDOUT_BIT] = id_out;
        stat_word[`DPLL_STAT_XOR_BIT] = xor_detector_out;
        stat_word[`DPLL_STAT_EDGE_BIT] = edge_detector_out;
        stat_word[`DPLL_STAT_BUSY_BIT] = id_busy;
    end

    // live modulus update, no reset of the counter needed
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            mod_sel_ff <= `DPLL_CTRL_RST;
        end
        else if (psel && penable && pwrite && hit_ctrl)
        begin
            mod_sel_ff <= pwdata[`DPLL_SEL_W-1:0];
        end
    end

    // read data is captured in setup so it is stable for the whole access
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            prdata <= '0;
        end
        else if (setup && !pwrite)
        begin
            if (hit_ctrl)
            begin
                prdata <= {28'h0000000, mod_sel_ff};
            end
            else if (hit_stat)
            begin
                prdata <= stat_word;
            end
            else
            begin
                prdata <= '0;
            end
        end
    end

    // ****************************************************************
    // phase detectors
    // ****************************************************************
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            xor_detector_out <= 1'b0;
        end
        else
        begin
            xor_detector_out <= xor_ref_phase_in ^ fb_phase_in;
        end
    end

    // feedback fall wins if both fall together, the output then tracks feedback
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            edge_detector_out <= 1'b0;
        end
        else if (fb_fall)
        begin
            edge_detector_out <= 1'b1;
        end
        else if (eref_fall)
        begin
            edge_detector_out <= 1'b0;
        end
    end

    // ****************************************************************
    // counter and i/d circuit
    // ****************************************************************
    dpll_kcounter u_kcnt (
        .core_clk(core_clk),
        .rst(rst),
        .k_rise(k_rise),
        .count_down(count_down),
        .counter_enable_n(counter_enable_n),
        .mod_sel(mod_sel_ff),
        .count_ff(count),
        .carry_ff(carry),
        .borrow_ff(borrow)
    );

    dpll_idcirc u_idc (
        .core_clk(core_clk),
        .rst(rst),
        .id_rise(id_rise),
        .id_fall(id_fall),
        .carry(carry),
        .borrow(borrow),
        .id_out_ff(id_out),
        .busy(id_busy)
    );

    // ****************************************************************
    // assertions
    // ****************************************************************
    dpll_cnt_t cur_mask;
    dpll_id_state_e id_state;

    assign cur_mask = dpll_mod_mask(mod_sel_ff);
    assign id_state = u_idc.state_ff;

    property p_inhibit;
        @(posedge core_clk) disable iff (rst)
        (mod_sel_ff == `DPLL_SEL_OFF) |=> (count == $past(count)) && !carry && !borrow;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("counter moved while inhibited");

    property p_wrap_up;
        @(posedge core_clk) disable iff (rst)
        (k_rise && !counter_enable_n && !count_down && (mod_sel_ff != `DPLL_SEL_OFF)
            && ((count & cur_mask) == cur_mask) && $stable(mod_sel_ff))
        |=> carry && !borrow && (count == '0) ##1 !carry;
    endproperty
    a_wrap_up: assert property (p_wrap_up) else $error("up wrap without single carry");

    property p_wrap_dn;
        @(posedge core_clk) disable iff (rst)
        (k_rise && !counter_enable_n && count_down && (mod_sel_ff != `DPLL_SEL_OFF)
            && ((count & cur_mask) == '0))
        |=> borrow && !carry && (count == $past(cur_mask)) ##1 !borrow;
    endproperty
    a_wrap_dn: assert property (p_wrap_dn) else $error("down wrap without single borrow");

    property p_step_up;
        @(posedge core_clk) disable iff (rst)
        (k_rise && !counter_enable_n && !count_down && (mod_sel_ff != `DPLL_SEL_OFF)
            && ((count & cur_mask) != cur_mask))
        |=> (count == (($past(count) & $past(cur_mask)) + 17'h00001)) && !carry;
    endproperty
    a_step_up: assert property (p_step_up) else $error("up count step wrong");

    property p_hold;
        @(posedge core_clk) disable iff (rst)
        (counter_enable_n || !k_rise) |=> (count == $past(count)) && !carry && !borrow;
    endproperty
    a_hold: assert property (p_hold) else $error("counter moved without enabled clock rise");

    property p_in_range;
        @(posedge core_clk) disable iff (rst)
        (k_rise && !counter_enable_n && (mod_sel_ff != `DPLL_SEL_OFF))
        ##1 $stable(mod_sel_ff) |-> ((count & ~cur_mask) == '0);
    endproperty
    a_in_range: assert property (p_in_range) else $error("count outside modulus");

    property p_half_rate;
        @(posedge core_clk) disable iff (rst)
        (id_rise && !id_busy) |=> (id_out != $past(id_out));
    endproperty
    a_half_rate: assert property (p_half_rate) else $error("idle output did not toggle");

    property p_idle_fall;
        @(posedge core_clk) disable iff (rst)
        (id_fall && !id_busy) |=> $stable(id_out);
    endproperty
    a_idle_fall: assert property (p_idle_fall) else $error("output moved on idle fall");

    property p_delete;
        @(posedge core_clk) disable iff (rst)
        (id_rise && (id_state == ID_DEL)) |=> $stable(id_out) && (id_state == ID_NORM);
    endproperty
    a_delete: assert property (p_delete) else $error("delete did not skip toggle");

    property p_insert;
        @(posedge core_clk) disable iff (rst)
        (id_fall && ((id_state == ID_INS_A) || (id_state == ID_INS_C)))
        |=> (id_out != $past(id_out));
    endproperty
    a_insert: assert property (p_insert) else $error("insert missed extra toggle");

    property p_xor;
        @(posedge core_clk) disable iff (rst)
        1'b1 |=> (xor_detector_out == $past(xor_ref_phase_in ^ fb_phase_in));
    endproperty
    a_xor: assert property (p_xor) else $error("xor detector mismatch");

    property p_edge;
        @(posedge core_clk) disable iff (rst)
        1'b1 |=> (edge_detector_out == ($past(fb_fall) ? 1'b1 :
            ($past(eref_fall) ? 1'b0 : $past(edge_detector_out))));
    endproperty
    a_edge: assert property (p_edge) else $error("edge detector wrong");

    property p_reset;
        @(posedge core_clk)
        rst |=> (count == '0) && !id_out && (id_state == ID_NORM);
    endproperty
    a_reset: assert property (p_reset) else $error("reset did not clear loop state");

    c_carry: cover property (@(posedge core_clk) disable iff (rst) carry);
    c_borrow: cover property (@(posedge core_clk) disable iff (rst) borrow);
    c_insert: cover property (@(posedge core_clk) disable iff (rst) id_state == ID_INS_C);
    c_sel_change: cover property (@(posedge core_clk) disable iff (rst)
        $changed(mod_sel_ff) && (count != '0));

endmodule

// ### tb/dpc_ndiv_model.sv
// Purpose: behavioural divide-by-n counter that closes the loop onto the feedback phase
// Assumes: id_out is synchronous to core_clk and each of its levels lasts a cycle or more
// Notes: n is a plain default; the loop centre then sits at id_clk over 2n
`timescale 1ns/1ps
module dpc_ndiv_model #(parameter int N = 4) (
    input wire logic core_clk, // system clock
    input wire logic rst,      // sync reset, active high
    input wire logic id_out,   // divided output of the core
    output logic fb_phase_in   // feedback phase to the core
);
    int cnt_ff;
    logic prev_ff;
    // ****************************************************************
    // divider, counts rises of the core output
    // ****************************************************************
    always_ff @(posedge core_clk)
    begin
        prev_ff <= rst ? 1'b0 : id_out;
        if (rst)
            cnt_ff <= 0;
        else if (id_out && !prev_ff)
            cnt_ff <= (cnt_ff == N - 1) ? 0 : cnt_ff + 1;
    end
    // square wave at 1/n of the core output rate
    assign fb_phase_in = (cnt_ff < N / 2);
endmodule

// ### tb/test_digital_pll_core.sv
// Purpose: self-checking bench for the digital pll core
// Assumes: apb answers with pready, loop clocks are slow levels driven here
// Notes: register reads are noted in a queue and judged by a monitor process
`timescale 1ns/1ps
`include "dpll_defs.svh"
module test_digital_pll_core;
    import dpll_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic k_clk = 1'b0;
    logic id_clk = 1'b0;
    logic count_down = 1'b0;
    logic counter_enable_n = 1'b1;
    logic xor_ref_phase_in = 1'b0;
    logic edge_ref_phase_in = 1'b0;
    logic fb_phase_in;
    logic xor_detector_out;
    logic edge_detector_out;
    logic id_out;
    int seed = 60;
    int n_fail = 0;
    int checks_done = 0;
    int id_tog = 0;
    logic [64:0] exp_q[$];
    logic [64:0] note;
    logic [16:0] cnt_m = 17'h0;
    logic [3:0] sel_m = 4'h0;
    logic xor_m = 1'b0;
    logic edge_m = 1'b0;
    logic fbp = 1'b0;
    logic refp = 1'b0;
    logic idp = 1'b0;
    logic chk_on = 1'b0;

    always #50 core_clk = ~core_clk;

    dpll_core dut_u (.core_clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .k_clk, .id_clk, .count_down, .counter_enable_n, .xor_ref_phase_in,
        .edge_ref_phase_in, .fb_phase_in, .xor_detector_out, .edge_detector_out, .id_out);
    dpc_ndiv_model #(.N(4)) ndiv_u (.core_clk, .rst, .id_out, .fb_phase_in);

    // ****************************************************************
    // reporting
    // ****************************************************************
    task check(input logic [32:0] seen, input logic [32:0] expv);
        checks_done++;
        if (seen !== expv)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, expv);
        end
    endtask

    task give_verdict;
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ****************************************************************
    // apb master and stimulus tasks
    // ****************************************************************
    task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int i;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        i = 0;
        @(posedge core_clk);
        while (pready !== 1'b1 && i < 20)
        begin
            @(posedge core_clk);
            i++;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        if (i >= 20)
        begin
            n_fail++;
            give_verdict;
        end
    endtask

    // expected value is pre-masked; bit 32 is the expected slave error
    task rd(input logic [11:0] a, input logic [32:0] e, input logic [31:0] m);
        exp_q.push_back({m, e});
        apb(a, 1'b0, 32'h0);
    endtask

    // direction and enable settle a cycle before the counter clock rises
    task kstep(input logic dn, input logic en_n);
        @(posedge core_clk);
        count_down <= dn;
        counter_enable_n <= en_n;
        @(posedge core_clk);
        k_clk <= 1'b1;
        repeat (2) @(posedge core_clk);
        k_clk <= 1'b0;
        if (!en_n && sel_m != 4'h0)
            cnt_m = (dn ? cnt_m - 17'h1 : cnt_m + 17'h1) & ((17'h1 << (sel_m + 2)) - 17'h1);
    endtask

    // e below zero only flushes, e.g. a pending insert left by earlier traffic
    task idrun(input int m, input int e);
        int t0;
        t0 = id_tog;
        repeat (m)
        begin
            @(posedge core_clk);
            id_clk <= 1'b1;
            repeat (2) @(posedge core_clk);
            id_clk <= 1'b0;
            @(posedge core_clk);
        end
        repeat (3) @(posedge core_clk);
        if (e >= 0)
            check(33'(id_tog - t0), 33'(e));
    endtask

    // ****************************************************************
    // monitors and reference models
    // ****************************************************************
    always @(negedge core_clk)
    begin
        if (chk_on)
        begin
            check({32'h0, xor_detector_out}, {32'h0, xor_m});
            check({32'h0, edge_detector_out}, {32'h0, edge_m});
        end
    end

    // read data is taken at the very edge that samples pready, as the master does
    always @(posedge core_clk)
    begin
        if (psel && penable && pready && !pwrite && exp_q.size() > 0)
        begin
            note = exp_q.pop_front();
            check({pslverr, prdata & note[64:33]}, note[32:0]);
        end
        idp <= id_out;
        if (id_out !== idp)
            id_tog++;
        if (chk_on)
        begin
            xor_ref_phase_in <= 1'($random(seed));
            edge_ref_phase_in <= 1'($random(seed));
        end
        fbp <= rst ? 1'b0 : fb_phase_in;
        refp <= rst ? 1'b0 : edge_ref_phase_in;
        xor_m <= rst ? 1'b0 : xor_ref_phase_in ^ fb_phase_in;
        if (rst)
            edge_m <= 1'b0;
        else if (fbp && !fb_phase_in)
            edge_m <= 1'b1;
        else if (refp && !edge_ref_phase_in)
            edge_m <= 1'b0;
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        chk_on <= 1'b1;
        rd(`DPLL_STAT_OFS, 33'h0, 32'h3ffff);
        rd(`DPLL_CTRL_OFS, 33'h0, 32'hffffffff);
        rd(12'h008, 33'h100000000, 32'hffffffff);
        apb(12'h00c, 1'b1, 32'hffffffff);
        apb(`DPLL_STAT_OFS, 1'b1, 32'hffffffff);
        rd(`DPLL_CTRL_OFS, 33'h0, 32'hffffffff);
        // every select code, then back to inhibit and a narrow width while counts stand
        for (int s = 0; s < 18; s++)
        begin
            sel_m = 4'(s);
            apb(`DPLL_CTRL_OFS, 1'b1, {28'h0, sel_m});
            repeat (8)
            begin
                kstep(1'($random(seed)), ($random(seed) & 3) == 0);
                rd(`DPLL_STAT_OFS, {16'h0, cnt_m}, 32'h1ffff);
            end
        end
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        cnt_m = 17'h0;
        sel_m = 4'h1;
        rd(`DPLL_STAT_OFS, 33'h0, 32'h3ffff);
        rd(`DPLL_CTRL_OFS, 33'h0, 32'hffffffff);
        apb(`DPLL_CTRL_OFS, 1'b1, 32'h1);
        idrun(8, 8);
        repeat (7) kstep(1'b0, 1'b0);
        rd(`DPLL_STAT_OFS, 33'h7, 32'h1ffff);
        kstep(1'b0, 1'b0);
        rd(`DPLL_STAT_OFS, 33'h100000, 32'h11ffff);
        idrun(8, 10);
        kstep(1'b1, 1'b0);
        idrun(8, 6);
        rd(`DPLL_STAT_OFS, 33'h7, 32'h11ffff);
        // closed loop: direction follows the xor detector, leftover requests get flushed
        repeat (6) kstep(xor_detector_out, 1'b0);
        idrun(2, -1);
        rd(`DPLL_STAT_OFS, {16'h0, cnt_m}, 32'h1ffff);
        repeat (4) @(posedge core_clk);
        give_verdict;
    end

    initial
    begin
        repeat (50000) @(posedge core_clk);
        n_fail++;
        give_verdict;
    end
endmodule
